/* igbt_cfg.svh */
`ifndef IGBT_CFG_SVH
`define IGBT_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define IGBT_OFS_CTRL0 8'h00
`define IGBT_OFS_CTRL1 8'h04
`define IGBT_OFS_START 8'h08
`define IGBT_OFS_COUNT 8'h0c
`define IGBT_OFS_CMP0 8'h10
`define IGBT_OFS_STAT 8'h14
`define IGBT_OFS_MASK 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IGBT_C0_DIV_LSB 0
`define IGBT_C0_DIV_MSB 4
`define IGBT_C0_DOWN 5
`define IGBT_C0_OVF14 6
`define IGBT_C1_RUN 0
`define IGBT_C1_SIB_EN 1
`define IGBT_C1_CMP_EN 2
`define IGBT_C1_EXT_EN 3
`define IGBT_C1_COM_EN 4
`define IGBT_ST_OVF 0
`define IGBT_ST_CMP 1

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define IGBT_CTRL0_RST 7'h00
`define IGBT_CTRL1_RST 5'h00
`define IGBT_START_RST 4'h0
`define IGBT_CNT_RST 16'h0000
`define IGBT_CMP_RST 16'hffff
`define IGBT_IRQ_RST 2'h0
`define IGBT_CTRL0_W 7
`define IGBT_CTRL1_W 5
`define IGBT_IRQ_W 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IGBT_DIV_BYPASS 5'h1f
`define IGBT_CMP_DELAY 2

`endif

/* igbt_pkg.sv */
package igbt_pkg;

   // Counter value type.
   typedef logic [15:0] igbt_cnt_t;

   // Counter states: stopped, being reset, counting.
   typedef enum logic [2:0] {
      IGBT_IDLE = 3'b001,
      IGBT_RST = 3'b010,
      IGBT_RUN = 3'b100
   } igbt_state_t;

endpackage

/* igbt_tick_div.sv */
`include "igbt_cfg.svh"

// Count source divider: one tick every 2(n+1) clocks, or every clock for n=31.
module igbt_tick_div (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [4:0] div_n,
   output logic tick
);

   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   wire logic [5:0] last = {div_n, 1'b1};
   wire logic bypass = (div_n == `IGBT_DIV_BYPASS);
   wire logic wrap = (cnt_ff >= last);

   // The tick comes at the end of each divided period.
   assign tick = bypass | wrap;
   assign nxt_cnt = (restart | wrap | bypass) ? 6'h00 : cnt_ff + 6'h01;

   // Divider counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 6'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

/* igbt_rst_ctl.sv */
`include "igbt_cfg.svh"

// Gathers the enabled counter reset sources into one request.
module igbt_rst_ctl #(
   parameter int GROUP_ID = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic running,
   input wire logic [15:0] count,
   input wire logic [15:0] cmp0,
   input wire logic sib_en,
   input wire logic cmp_en,
   input wire logic ext_en,
   input wire logic com_en,
   input wire logic sib_reset_in,
   input wire logic ext_low,
   input wire logic comm_reset_req,
   output logic match,
   output logic reset_req
);

   logic [`IGBT_CMP_DELAY-1:0] dly_ff;
   wire logic com_ok = (GROUP_ID == 2);

   // A match is seen on a counter tick while running.
   assign match = running & tick & (count == cmp0);

   // Any enabled source resets the counter; the comms source only in group 2.
   assign reset_req = (sib_en & sib_reset_in)
                    | (cmp_en & dly_ff[`IGBT_CMP_DELAY-1] & tick) // RULE7
                    | (ext_en & ext_low) // RULE8
                    | (com_ok & com_en & comm_reset_req); // RULE9

   // Match delay line advanced by counter ticks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_ff <= '0;
      end else if (!running) begin
         dly_ff <= '0;
      end else if (tick) begin
         dly_ff <= {dly_ff[`IGBT_CMP_DELAY-2:0], match}; // RULE7
      end
   end

endmodule

/* igbt_top.sv */
// Decided for this implementation: the placing of the registers and register access over APB.
`include "igbt_cfg.svh"

// Summary of operation
// (RULE1) Each group has one free-running 16-bit counter as its time base.
// (RULE2) Counter ticks at clock divided by 2(n+1); n=31 means undivided.
// (RULE3) Counting direction is selectable, up or down.
// (RULE4) Writing one to either run bit clears the count and starts counting.
// (RULE5) Counter stops only when both run bits are zero.
// (RULE6) Optional reset together with the sibling group's counter.
// (RULE7) Optional reset two ticks after count equals compare channel 0.
// (RULE8) Optional reset by low level on the group's external pin.
// (RULE9) Group 2 may be reset by the comms helper; sources combine by OR.
// (RULE10) Interrupt on overflow out of bit 14 or bit 15, as selected.
// (RULE11) Reads while running return the live count; stopped reads undefined.
// (RULE12) Writes during reset are lost; writes while running load the count.
// (RULE13) Software programs cascade patterns into both control register 1s.
// (RULE14) Software uses equal dividers and a start, stop, start sequence.
// (RULE15) Shared start register acts only after control register 0 is written.
// (RULE16) Counter wraps modulo 65536 and keeps counting.
module igbt_top #(
   parameter int GROUP_ID = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sib_reset_in,
   input wire logic ext_reset_pin_a_n,
   input wire logic ext_reset_pin_b_n,
   input wire logic comm_reset_req,
   output logic sib_reset_out,
   output logic irq
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [`IGBT_CTRL0_W-1:0] ctrl0_ff;
   logic [`IGBT_CTRL1_W-1:0] ctrl1_ff;
   logic [3:0] start_ff;
   logic ctrl0_set_ff;
   igbt_pkg::igbt_cnt_t cnt_ff;
   igbt_pkg::igbt_cnt_t nxt_cnt;
   igbt_pkg::igbt_cnt_t cmp0_ff;
   logic [`IGBT_IRQ_W-1:0] stat_ff;
   logic [`IGBT_IRQ_W-1:0] nxt_stat;
   logic [`IGBT_IRQ_W-1:0] mask_ff;
   igbt_pkg::igbt_state_t state_ff;
   igbt_pkg::igbt_state_t nxt_state;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic sib_out_ff;
   logic irq_ff;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------

   // Returns one when the address names a mapped register.
   function automatic logic igbt_mapped(input logic [7:0] a);
      igbt_mapped = (a == `IGBT_OFS_CTRL0) | (a == `IGBT_OFS_CTRL1)
                  | (a == `IGBT_OFS_START) | (a == `IGBT_OFS_COUNT)
                  | (a == `IGBT_OFS_CMP0) | (a == `IGBT_OFS_STAT)
                  | (a == `IGBT_OFS_MASK);
   endfunction

   // The access phase ends one cycle after penable rises.
   wire logic acc_first = psel & penable & ~pready_ff;
   wire logic acc_done = psel & penable & pready_ff;
   wire logic wr = acc_done & pwrite;
   wire logic wr_c0 = wr & (paddr == `IGBT_OFS_CTRL0);
   wire logic wr_c1 = wr & (paddr == `IGBT_OFS_CTRL1);
   wire logic wr_st = wr & (paddr == `IGBT_OFS_START);
   wire logic wr_cnt = wr & (paddr == `IGBT_OFS_COUNT);
   wire logic wr_cmp = wr & (paddr == `IGBT_OFS_CMP0);
   wire logic wr_stat = wr & (paddr == `IGBT_OFS_STAT);
   wire logic wr_mask = wr & (paddr == `IGBT_OFS_MASK);

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   wire logic [4:0] div_n = ctrl0_ff[`IGBT_C0_DIV_MSB:`IGBT_C0_DIV_LSB];
   wire logic cnt_down = ctrl0_ff[`IGBT_C0_DOWN];
   wire logic ovf14 = ctrl0_ff[`IGBT_C0_OVF14];

   // The shared start register is ignored until control 0 is written.
   wire logic st_ok = ctrl0_set_ff | wr_c0; // RULE15
   wire logic st_wr_ok = wr_st & st_ok; // RULE15
   wire logic [3:0] nxt_start = st_wr_ok ? pwdata[3:0] : start_ff;
   wire logic [`IGBT_CTRL1_W-1:0] nxt_ctrl1 =
      wr_c1 ? pwdata[`IGBT_CTRL1_W-1:0] : ctrl1_ff;

   // A one written to either run bit restarts from zero.
   wire logic start_req = (wr_c1 & pwdata[`IGBT_C1_RUN])
                        | (st_wr_ok & pwdata[GROUP_ID]); // RULE4

   // Running holds while either run bit is one.
   wire logic run_any = nxt_ctrl1[`IGBT_C1_RUN] | nxt_start[GROUP_ID]; // RULE5

   // The group's own external pin, pin a for group 0 and pin b for group 1.
   wire logic ext_low = (GROUP_ID == 0) ? ~ext_reset_pin_a_n
                      : (GROUP_ID == 1) ? ~ext_reset_pin_b_n
                      : 1'b0; // RULE8

   // ----------------------------------------------------------------
   // Count source and reset sources
   // ----------------------------------------------------------------
   wire logic running = (state_ff == igbt_pkg::IGBT_RUN);
   logic tick;
   logic match;
   logic src_reset;

   // The divider restarts on a start request so the first period is whole; reset sources leave its phase alone.
   igbt_tick_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .restart(start_req),
      .div_n(div_n),
      .tick(tick)
   ); // RULE2

   // Sibling, compare, pin and comms resets combine by OR.
   igbt_rst_ctl #(
      .GROUP_ID(GROUP_ID)
   ) u_rst (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .running(running),
      .count(cnt_ff),
      .cmp0(cmp0_ff),
      .sib_en(ctrl1_ff[`IGBT_C1_SIB_EN]),
      .cmp_en(ctrl1_ff[`IGBT_C1_CMP_EN]),
      .ext_en(ctrl1_ff[`IGBT_C1_EXT_EN]),
      .com_en(ctrl1_ff[`IGBT_C1_COM_EN]),
      .sib_reset_in(sib_reset_in),
      .ext_low(ext_low),
      .comm_reset_req(comm_reset_req),
      .match(match),
      .reset_req(src_reset)
   ); // RULE6 RULE9

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------

   // Overflow out of bit 15 or bit 14, for either direction.
   function automatic logic igbt_ovf(input logic [15:0] c, input logic dn,
                                     input logic b14);
      logic lo_full;
      logic lo_zero;
      lo_full = &c[14:0];
      lo_zero = ~|c[14:0];
      if (dn) begin
         igbt_ovf = b14 ? lo_zero : (lo_zero & ~c[15]);
      end else begin
         igbt_ovf = b14 ? lo_full : (lo_full & c[15]);
      end
   endfunction

   wire logic do_reset = running & src_reset & ~start_req;
   wire logic do_load = running & wr_cnt & ~src_reset & ~start_req; // RULE12
   wire logic do_step = running & tick & ~src_reset & ~do_load;
   wire logic ovf_evt = do_step & igbt_ovf(cnt_ff, cnt_down, ovf14); // RULE10
   wire logic cmp_evt = match;

   // Next state: a start, or a reset source while running, passes through reset.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         igbt_pkg::IGBT_IDLE: begin
            if (start_req) begin
               nxt_state = igbt_pkg::IGBT_RST; // RULE4
            end
         end
         igbt_pkg::IGBT_RST: begin
            nxt_state = run_any ? igbt_pkg::IGBT_RUN : igbt_pkg::IGBT_IDLE;
         end
         igbt_pkg::IGBT_RUN: begin
            if (start_req | do_reset) begin
               nxt_state = igbt_pkg::IGBT_RST;
            end else if (!run_any) begin
               nxt_state = igbt_pkg::IGBT_IDLE; // RULE5
            end
         end
         default: begin
            nxt_state = igbt_pkg::IGBT_IDLE;
         end
      endcase
   end

   // Next count. Writes during reset fall through and are lost.
   always_comb begin
      nxt_cnt = cnt_ff;
      if (state_ff == igbt_pkg::IGBT_RST) begin
         nxt_cnt = `IGBT_CNT_RST; // RULE4 RULE12
      end else if (do_load) begin
         nxt_cnt = pwdata[15:0]; // RULE12
      end else if (do_step) begin
         nxt_cnt = cnt_down ? cnt_ff - 16'h0001
                            : cnt_ff + 16'h0001; // RULE3 RULE16
      end
   end

   // Counter and state flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= igbt_pkg::IGBT_IDLE;
         cnt_ff <= `IGBT_CNT_RST;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt; // RULE1
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------

   // Control, start and compare registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_ff <= `IGBT_CTRL0_RST;
         ctrl1_ff <= `IGBT_CTRL1_RST;
         start_ff <= `IGBT_START_RST;
         ctrl0_set_ff <= 1'b0;
         cmp0_ff <= `IGBT_CMP_RST;
      end else begin
         if (wr_c0) begin
            ctrl0_ff <= pwdata[`IGBT_CTRL0_W-1:0];
            ctrl0_set_ff <= 1'b1; // RULE15
         end
         ctrl1_ff <= nxt_ctrl1;
         start_ff <= nxt_start;
         if (wr_cmp) begin
            cmp0_ff <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   wire logic [`IGBT_IRQ_W-1:0] evt = {cmp_evt, ovf_evt};
   wire logic [`IGBT_IRQ_W-1:0] clr =
      wr_stat ? pwdata[`IGBT_IRQ_W-1:0] : '0;

   // A new event wins over a write-one clear in the same cycle.
   assign nxt_stat = (stat_ff & ~clr) | evt; // RULE10

   // Sticky status, mask and the level interrupt.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_ff <= `IGBT_IRQ_RST;
         mask_ff <= `IGBT_IRQ_RST;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (wr_mask) begin
            mask_ff <= pwdata[`IGBT_IRQ_W-1:0];
         end
         irq_ff <= |(nxt_stat & (wr_mask ? pwdata[`IGBT_IRQ_W-1:0]
                                         : mask_ff));
      end
   end

   // ----------------------------------------------------------------
   // Read path and bus answer
   // ----------------------------------------------------------------

   // Read mux; the count reads live, stopped reads see the held value.
   wire logic [31:0] rd_mux =
      (paddr == `IGBT_OFS_CTRL0) ? {25'h0, ctrl0_ff} :
      (paddr == `IGBT_OFS_CTRL1) ? {27'h0, ctrl1_ff} :
      (paddr == `IGBT_OFS_START) ? {28'h0, start_ff} :
      (paddr == `IGBT_OFS_COUNT) ? {16'h0, cnt_ff} : // RULE11
      (paddr == `IGBT_OFS_CMP0) ? {16'h0, cmp0_ff} :
      (paddr == `IGBT_OFS_STAT) ? {30'h0, stat_ff} :
      (paddr == `IGBT_OFS_MASK) ? {30'h0, mask_ff} :
      32'h0000_0000;

   // One wait state: data and ready rise together from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc_first;
         pslverr_ff <= acc_first & ~igbt_mapped(paddr);
         prdata_ff <= (acc_first & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Pulse to the sibling group whenever this counter is reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sib_out_ff <= 1'b0;
      end else begin
         sib_out_ff <= do_reset | start_req; // RULE6
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign sib_reset_out = sib_out_ff;
   assign irq = irq_ff;

endmodule

/* igbt_props.sv */
`include "igbt_cfg.svh"

// ---------------------------------------------------------------
// Checker on the register bus and the timer's pins
// ---------------------------------------------------------------
module igbt_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sib_reset_in,
   input wire logic ext_reset_pin_a_n,
   input wire logic ext_reset_pin_b_n,
   input wire logic comm_reset_req,
   input wire logic sib_reset_out,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // The first access cycle waits, the second completes.
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   a_ready_wait: assert property (s_wait |=> pready)
      else $error("access phase did not end after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_cause: assert property (pready |-> psel && penable &&
      $past(psel && penable)) else $error("pready without a waited access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside the answer cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside the answer cycle");
   a_err_unmap: assert property (s_done and paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (s_done and paddr <= 8'h18 &&
      paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access refused");
   a_start_pulse: assert property (s_done and pwrite && pwdata[0] &&
      paddr == `IGBT_OFS_CTRL1 |-> ##[1:3] sib_reset_out)
      else $error("start did not announce a counter reset");
   a_mask_off: assert property (s_done and pwrite &&
      paddr == `IGBT_OFS_MASK && pwdata[1:0] == 2'b00 |-> ##2 !irq)
      else $error("irq stayed high with all events masked");
   a_upper_zero: assert property (pready && !pwrite &&
      paddr == `IGBT_OFS_COUNT |-> prdata[31:16] == 16'h0000)
      else $error("count read wider than sixteen bits");
endmodule

bind igbt_top igbt_props u_igbt_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sib_reset_in(sib_reset_in), .ext_reset_pin_a_n(ext_reset_pin_a_n),
   .ext_reset_pin_b_n(ext_reset_pin_b_n), .comm_reset_req(comm_reset_req),
   .sib_reset_out(sib_reset_out), .irq(irq));

/* igbt_nbr_model.sv */
// ---------------------------------------------------------------
// Neighbouring group, external pins and comms helper
// ---------------------------------------------------------------
module igbt_nbr_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] req,
   input wire logic sib_reset_out,
   output logic sib_reset_in,
   output logic ext_reset_pin_a_n,
   output logic ext_reset_pin_b_n,
   output logic comm_reset_req,
   output logic [7:0] peer_starts
);
   timeunit 1ns;
   timeprecision 100ps;

   // Requests reach the pins one edge later; idle pins rest high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sib_reset_in <= 1'b0;
         ext_reset_pin_a_n <= 1'b1;
         ext_reset_pin_b_n <= 1'b1;
         comm_reset_req <= 1'b0;
         peer_starts <= 8'h00;
      end else begin
         sib_reset_in <= req[0];
         ext_reset_pin_a_n <= !req[1];
         ext_reset_pin_b_n <= !req[2];
         comm_reset_req <= req[3];
         peer_starts <= peer_starts + {7'h00, sib_reset_out};
      end
   end
endmodule

/* io_group_base_timer_test.sv */
`include "igbt_cfg.svh"

// ---------------------------------------------------------------
// Self-checking bench for one timer group
// ---------------------------------------------------------------
module io_group_base_timer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic pready, pslverr, sib_in, pin_a_n, pin_b_n, comm, sib_out, irq, e;
   logic [3:0] req = 4'h0;
   logic [7:0] peer;
   logic [31:0] mdl [0:7];
   logic [31:0] wmask [0:7];
   logic c0_done = 1'b0;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   int t_rdy = 0;
   int seed = 12308;

   always #12.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   igbt_top #(.GROUP_ID(0)) u_igbt_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sib_reset_in(sib_in), .ext_reset_pin_a_n(pin_a_n),
      .ext_reset_pin_b_n(pin_b_n), .comm_reset_req(comm),
      .sib_reset_out(sib_out), .irq(irq));
   igbt_nbr_model u_igbt_nbr_model (.pclk(pclk), .presetn(presetn),
      .req(req), .sib_reset_out(sib_out), .sib_reset_in(sib_in),
      .ext_reset_pin_a_n(pin_a_n), .ext_reset_pin_b_n(pin_b_n),
      .comm_reset_req(comm), .peer_starts(peer));

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is sampled.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) n_mismatch++;
      r = prdata;
      e = pslverr;
      t_rdy = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Writes a register and updates the reference copy.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == `IGBT_OFS_CTRL0) c0_done = 1'b1;
      if (a != `IGBT_OFS_START || c0_done) begin
         mdl[a[4:2]] = d & wmask[a[4:2]];
      end
   endtask

   // Reads a register and compares it with the reference copy.
   task automatic rdm(input logic [7:0] a);
      apb(1'b0, a, $random(seed));
      chk(r, mdl[a[4:2]]);
      chk({31'h0, e}, 32'h0);
   endtask

   // Two count reads a whole number of ticks apart.
   task automatic rate(input int p, input int s);
      logic [15:0] v1, d;
      int t1;
      apb(1'b0, `IGBT_OFS_COUNT, 32'h0);
      v1 = r[15:0];
      t1 = t_rdy;
      while ((cyc + 4 - t1) % p != 0) @(posedge pclk);
      apb(1'b0, `IGBT_OFS_COUNT, 32'h0);
      d = r[15:0] - v1;
      v1 = 16'(s * (t_rdy - t1) / p);
      chk({16'h0, d}, {16'h0, v1});
   endtask

   // Reads the count and checks it lies in lo..hi.
   task automatic cnt_in(input logic [15:0] lo, input logic [15:0] hi);
      apb(1'b0, `IGBT_OFS_COUNT, 32'h0);
      chk({31'h0, r[15:0] >= lo && r[15:0] <= hi}, 32'h1);
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #2_000_000;
      n_mismatch++;
      summarize();
   end

   // Main sequence of scenarios.
   initial begin
      wmask = '{32'h7f, 32'h1f, 32'hf, 32'h0, 32'hffff, 32'h0, 32'h3, 32'h0};
      mdl = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) if (i != 3 && i != 5) rdm(8'(i * 4));
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      wr(`IGBT_OFS_START, 32'h1);
      rdm(`IGBT_OFS_START);
      $display("test regs done");
      wr(`IGBT_OFS_CTRL1, 32'h81);
      rdm(`IGBT_OFS_CTRL1);
      rate(2, 1);
      foreach (wmask[i]) if (i < 4) begin
         wr(`IGBT_OFS_CTRL0, 32'(i == 3 ? 6'h3f : (i == 0 ? 31 : i * 3)));
         wr(`IGBT_OFS_CTRL1, 32'h1);
         rate(i == 0 || i == 3 ? 1 : 2 * (i * 3 + 1), i == 3 ? -1 : 1);
      end
      wr(`IGBT_OFS_CTRL0, 32'h1f);
      wr(`IGBT_OFS_COUNT, 32'hdead_1234);
      wr(`IGBT_OFS_CTRL1, 32'h1);
      cnt_in(16'h0000, 16'h0007);
      $display("test rate done");
      wr(`IGBT_OFS_STAT, 32'h3);
      wr(`IGBT_OFS_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`IGBT_OFS_COUNT, 32'hfff0);
      cnt_in(16'hfff0, 16'hfff7);
      repeat (30) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      cnt_in(16'h0000, 16'h0040);
      wr(`IGBT_OFS_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(`IGBT_OFS_CTRL0, 32'h5f);
      wr(`IGBT_OFS_COUNT, 32'h7ff0);
      repeat (30) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(`IGBT_OFS_STAT, 32'h3);
      wr(`IGBT_OFS_CTRL0, 32'h3f);
      wr(`IGBT_OFS_COUNT, 32'h5);
      repeat (20) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      cnt_in(16'hffd0, 16'hffff);
      wr(`IGBT_OFS_MASK, 32'h0);
      $display("test overflow done");
      wr(`IGBT_OFS_CTRL0, 32'h1f);
      wr(`IGBT_OFS_CMP0, 32'($random(seed)));
      rdm(`IGBT_OFS_CMP0);
      wr(`IGBT_OFS_CMP0, 32'h40);
      wr(`IGBT_OFS_CTRL1, 32'h5);
      repeat (8) begin
         repeat ($random(seed) & 32'h1f) @(posedge pclk);
         cnt_in(16'h0000, 16'h0042);
      end
      $display("test compare done");
      wr(`IGBT_OFS_CTRL1, 32'h9);
      req <= 4'h2;
      repeat (5) @(posedge pclk);
      cnt_in(16'h0000, 16'h0001);
      req <= 4'h4;
      repeat (20) @(posedge pclk);
      cnt_in(16'h000a, 16'h0030);
      wr(`IGBT_OFS_CTRL1, 32'h13);
      req <= 4'h1;
      repeat (5) @(posedge pclk);
      cnt_in(16'h0000, 16'h0001);
      req <= 4'h8;
      repeat (20) @(posedge pclk);
      cnt_in(16'h000a, 16'h0030);
      chk({31'h0, peer > 8'h1}, 32'h1);
      req <= 4'h0;
      $display("test sources done");
      wr(`IGBT_OFS_START, 32'h1);
      wr(`IGBT_OFS_CTRL1, 32'h0);
      rate(1, 1);
      wr(`IGBT_OFS_START, 32'h1);
      wr(`IGBT_OFS_START, 32'h0);
      wr(`IGBT_OFS_START, 32'h1);
      cnt_in(16'h0000, 16'h0007);
      rdm(`IGBT_OFS_START);
      $display("test start done");
      summarize();
   end
endmodule
